// >>> logic/flag_bus_pkg.sv
package flag_bus_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int QUEUES      = 4;
    localparam int ADDR_W      = 5;
    localparam int IDENT_W     = 3;
    localparam int SIDES       = 2;
    localparam int SIDE_FULL   = 0;
    localparam int SIDE_EMPTY  = 1;

    // ------------------------------------------------------------
    // Packet flag timing, in read-side clock cycles
    // ------------------------------------------------------------
    localparam int FALL_CYCLES = 2;
    localparam int RISE_CYCLES = 3;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] QCFG_OFF   = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] COUNT_OFF  = 12'h008;
    localparam logic [3:0]  QCFG_RESET = 4'hf;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic              bus_strobe;
        logic [ADDR_W-1:0] port_address;
        logic              token_in;
    } side_req_t;

    typedef struct packed {
        logic [QUEUES-1:0] status_bus_n;
        logic              status_bus_oe;
        logic              token_out;
        logic              sync_pulse;
    } side_out_t;

    typedef struct packed {
        logic               polled;
        logic               chain_master;
        logic               packet_mode;
        logic [IDENT_W-1:0] identity;
    } straps_t;

endpackage

// >>> logic/multi_queue_flag_bus_expansion.sv
`timescale 1ns/1ps

// Functional notes
// - Packet flag edges timed by read clock
// - Packet flag falls on end after start
// - Fall two read cycles after end word
// - Read queue switch adds one cycle
// - Flag rises three cycles after last start
// - Full bus taken on strobe and match
// - Upper address bits compared with identity
// - Full bus shows new owner next cycle
// - Full bus bit may lag once
// - Polled mode, master owns first edge
// - Master sync high while owning full bus
// - Full token high in owning cycle
// - Four bit bus, queue n on bit n
// - Active read queue on discrete flags, write queue on almost-full
// - Packet mode picks packet or almost-empty
// - Only owning device drives shared bus
// - Mode strap picks direct or polled
// - Empty bus taken on strobe and match
// - Empty bus shows new owner next cycle
// - Empty bus bit may lag once
// - Master sync high while owning empty bus
// - Empty token high in owning cycle
module multi_queue_flag_bus_expansion #(
    parameter int CNT_W = 8
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic [11:0]                 paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        master_reset_n,
    input  wire logic                        flag_bus_mode_select,
    input  wire logic                        chain_master_select,
    input  wire logic                        packet_mode_select,
    input  wire logic [2:0]                  device_identity_inputs,
    input  wire logic                        wr_en,
    input  wire logic [1:0]                  wr_queue,
    input  wire logic                        write_end_of_packet_marker,
    input  wire logic                        write_start_of_packet_marker,
    input  wire logic                        rd_en,
    input  wire logic [1:0]                  rd_queue,
    input  wire logic                        read_start_of_packet_marker,
    input  wire logic                        rd_queue_switch,
    input  wire logic [3:0]                  almost_full_level_n,
    input  wire logic [3:0]                  almost_empty_level_n,
    input  wire logic [3:0]                  queue_not_empty,
    input  wire flag_bus_pkg::side_req_t     full_side_req,
    input  wire flag_bus_pkg::side_req_t     empty_side_req,
    output flag_bus_pkg::side_out_t          full_side_out,
    output flag_bus_pkg::side_out_t          empty_side_out,
    output logic                             almost_full_flag_n,
    output logic                             almost_empty_flag_n,
    output logic                             packet_ready_flag_n,
    output logic                             output_valid_flag_n
);

    localparam int Q = flag_bus_pkg::QUEUES;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // Straps caught while master reset is low
    // ------------------------------------------------------------
    flag_bus_pkg::straps_t straps_q;
    logic                  mrs_low_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            straps_q <= '0;
        else if (!master_reset_n)
        begin
            straps_q.polled       <= flag_bus_mode_select;
            straps_q.chain_master <= chain_master_select;
            straps_q.packet_mode  <= packet_mode_select;
            straps_q.identity     <= device_identity_inputs;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mrs_low_q <= 1'b1;
        else
            mrs_low_q <= !master_reset_n;
    end

    // ------------------------------------------------------------
    // Packet completion and read-out events
    // ------------------------------------------------------------
    logic [Q-1:0] start_seen_q;
    logic [Q-1:0] wr_done_vec;
    logic [Q-1:0] rd_start_vec;
    logic [Q-1:0] wr_onehot;
    logic [Q-1:0] rd_onehot;

    assign wr_onehot    = 4'h1 << wr_queue;
    assign rd_onehot    = 4'h1 << rd_queue;
    assign wr_done_vec  = (wr_en && write_end_of_packet_marker &&
                           ((|(start_seen_q & wr_onehot)) ||
                            write_start_of_packet_marker))
                          ? wr_onehot : 4'h0;
    assign rd_start_vec = (rd_en && read_start_of_packet_marker)
                          ? rd_onehot : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_seen_q <= 4'h0;
        else if (!master_reset_n)
            start_seen_q <= 4'h0;
        else if (wr_en && write_end_of_packet_marker)
            start_seen_q <= start_seen_q & ~wr_onehot;
        else if (wr_en && write_start_of_packet_marker)
            start_seen_q <= start_seen_q | wr_onehot;
    end

    // ------------------------------------------------------------
    // Flag delay lines, one extra cycle on a read queue switch
    // ------------------------------------------------------------
    logic [Q-1:0] inc_s1_q;
    logic [Q-1:0] inc_s2_q;
    logic [Q-1:0] inc_late_q;
    logic [Q-1:0] dec_s1_q;
    logic [Q-1:0] dec_s2_q;
    logic [Q-1:0] dec_s3_q;
    logic [Q-1:0] dec_late_q;
    logic [Q-1:0] inc_apply;
    logic [Q-1:0] dec_apply;

    assign inc_apply = (rd_queue_switch ? 4'h0 : inc_s2_q) | inc_late_q;
    assign dec_apply = (rd_queue_switch ? 4'h0 : dec_s3_q) | dec_late_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            inc_s1_q   <= 4'h0;
            inc_s2_q   <= 4'h0;
            inc_late_q <= 4'h0;
            dec_s1_q   <= 4'h0;
            dec_s2_q   <= 4'h0;
            dec_s3_q   <= 4'h0;
            dec_late_q <= 4'h0;
        end
        else if (!master_reset_n)
        begin
            inc_s1_q   <= 4'h0;
            inc_s2_q   <= 4'h0;
            inc_late_q <= 4'h0;
            dec_s1_q   <= 4'h0;
            dec_s2_q   <= 4'h0;
            dec_s3_q   <= 4'h0;
            dec_late_q <= 4'h0;
        end
        else
        begin
            inc_s1_q   <= wr_done_vec;
            inc_s2_q   <= inc_s1_q;
            inc_late_q <= rd_queue_switch ? inc_s2_q : 4'h0;
            dec_s1_q   <= rd_start_vec;
            dec_s2_q   <= dec_s1_q;
            dec_s3_q   <= dec_s2_q;
            dec_late_q <= rd_queue_switch ? dec_s3_q : 4'h0;
        end
    end

    // ------------------------------------------------------------
    // Complete packet counts and packet-ready bits (active low)
    // ------------------------------------------------------------
    logic [CNT_W-1:0] cnt_q [Q];
    logic [Q-1:0]     packet_ready_n_q;

    genvar gq;
    for (gq = 0; gq < Q; gq++)
    begin : g_queue
        logic [CNT_W-1:0] cnt_d;

        always_comb
        begin
            cnt_d = cnt_q[gq];
            if (inc_apply[gq] && (cnt_d != {CNT_W{1'b1}}))
                cnt_d = cnt_d + 1'b1;
            if (dec_apply[gq] && (cnt_d != '0))
                cnt_d = cnt_d - 1'b1;
        end

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cnt_q[gq]            <= '0;
                packet_ready_n_q[gq] <= 1'b1;
            end
            else if (!master_reset_n)
            begin
                cnt_q[gq]            <= '0;
                packet_ready_n_q[gq] <= 1'b1;
            end
            else
            begin
                cnt_q[gq]            <= cnt_d;
                packet_ready_n_q[gq] <= (cnt_d == '0);
            end
        end
    end

    // ------------------------------------------------------------
    // Discrete flags of the active queues
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            almost_full_flag_n  <= 1'b1;
            almost_empty_flag_n <= 1'b0;
            packet_ready_flag_n <= 1'b1;
            output_valid_flag_n <= 1'b1;
        end
        else
        begin
            almost_full_flag_n  <= almost_full_level_n[wr_queue];
            almost_empty_flag_n <= almost_empty_level_n[rd_queue];
            packet_ready_flag_n <= packet_ready_n_q[rd_queue];
            output_valid_flag_n <= !queue_not_empty[rd_queue];
        end
    end

    // ------------------------------------------------------------
    // Shared status buses and ownership, one per side
    // ------------------------------------------------------------
    logic [3:0]              qcfg_q;
    logic [1:0]              own_q;
    flag_bus_pkg::side_req_t req_a [flag_bus_pkg::SIDES];
    logic [Q-1:0]            src_a [flag_bus_pkg::SIDES];
    logic [Q-1:0]            bus_q [flag_bus_pkg::SIDES];
    flag_bus_pkg::side_out_t out_a [flag_bus_pkg::SIDES];

    assign req_a[flag_bus_pkg::SIDE_FULL]  = full_side_req;
    assign req_a[flag_bus_pkg::SIDE_EMPTY] = empty_side_req;
    assign src_a[flag_bus_pkg::SIDE_FULL]  = almost_full_level_n;
    assign src_a[flag_bus_pkg::SIDE_EMPTY] = straps_q.packet_mode
                                             ? packet_ready_n_q
                                             : almost_empty_level_n;
    assign full_side_out  = out_a[flag_bus_pkg::SIDE_FULL];
    assign empty_side_out = out_a[flag_bus_pkg::SIDE_EMPTY];

    genvar gs;
    for (gs = 0; gs < flag_bus_pkg::SIDES; gs++)
    begin : g_side
        logic sel_match;

        assign sel_match = req_a[gs].port_address[4:2]
                           == straps_q.identity;

        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                own_q[gs] <= 1'b0;
            else if (!master_reset_n)
                own_q[gs] <= 1'b0;
            else if (straps_q.polled)
                own_q[gs] <= (straps_q.chain_master && mrs_low_q) ||
                             req_a[gs].token_in;
            else if (req_a[gs].bus_strobe)
                own_q[gs] <= sel_match;
        end

        // Unconfigured queues read as high
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
                bus_q[gs] <= 4'hf;
            else
                bus_q[gs] <= src_a[gs] | ~qcfg_q;
        end

        assign out_a[gs].status_bus_n  = bus_q[gs];
        assign out_a[gs].status_bus_oe = own_q[gs];
        assign out_a[gs].token_out     = own_q[gs] && straps_q.polled;
        assign out_a[gs].sync_pulse    = own_q[gs] && straps_q.polled &&
                                         straps_q.chain_master;
    end

    // ------------------------------------------------------------
    // APB slave, zero wait states
    // ------------------------------------------------------------
    logic        setup;
    logic        access;
    logic        mapped;
    logic [31:0] rd_mux;

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign mapped = (paddr == flag_bus_pkg::QCFG_OFF) ||
                    (paddr == flag_bus_pkg::STATUS_OFF) ||
                    (paddr == flag_bus_pkg::COUNT_OFF);
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    always_comb
    begin
        rd_mux = 32'h0;
        case (paddr)
            flag_bus_pkg::QCFG_OFF:
                rd_mux = {28'h0, qcfg_q};
            flag_bus_pkg::STATUS_OFF:
                rd_mux = {20'h0, straps_q, own_q, packet_ready_n_q};
            flag_bus_pkg::COUNT_OFF:
                rd_mux = {cnt_q[3][7:0], cnt_q[2][7:0],
                          cnt_q[1][7:0], cnt_q[0][7:0]};
            default:
                rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0;
        else if (setup && !pwrite)
            prdata <= rd_mux;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            qcfg_q <= flag_bus_pkg::QCFG_RESET;
        else if (access && pwrite && (paddr == flag_bus_pkg::QCFG_OFF))
            qcfg_q <= pwdata[3:0];
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence polled_start_s;
        master_reset_n && mrs_low_q && straps_q.polled &&
        straps_q.chain_master;
    endsequence

    sequence direct_pick_s (int s);
        !straps_q.polled && master_reset_n && req_a[s].bus_strobe;
    endsequence

    packet_fall_a: assert property (
        $fell(packet_ready_n_q[0]) && $past(master_reset_n) |->
        $past(wr_done_vec[0], 3) || $past(wr_done_vec[0], 4))
        else $error("packet flag fell without end word");

    packet_rise_a: assert property (
        $rose(packet_ready_n_q[0]) && $past(master_reset_n) |->
        $past(rd_start_vec[0], 4) || $past(rd_start_vec[0], 5))
        else $error("packet flag rose without start read");

    full_select_a: assert property (
        direct_pick_s(0) ##0 g_side[0].sel_match |=>
        full_side_out.status_bus_oe)
        else $error("full bus not taken on select");

    full_release_a: assert property (
        direct_pick_s(0) ##0 !g_side[0].sel_match |=>
        !full_side_out.status_bus_oe)
        else $error("full bus kept after other select");

    empty_select_a: assert property (
        direct_pick_s(1) ##0 g_side[1].sel_match |=>
        empty_side_out.status_bus_oe && empty_side_out.status_bus_n ==
        ($past(src_a[1]) | ~$past(qcfg_q)))
        else $error("empty bus wrong after select");

    master_first_a: assert property (
        polled_start_s |=> full_side_out.sync_pulse &&
        empty_side_out.sync_pulse)
        else $error("master missed first bus cycle");

    token_pass_a: assert property (
        straps_q.polled && master_reset_n && full_side_req.token_in |=>
        full_side_out.token_out && full_side_out.status_bus_oe)
        else $error("token not taken");

    reset_release_a: assert property (
        !master_reset_n |=> !full_side_out.status_bus_oe &&
        !empty_side_out.status_bus_oe)
        else $error("bus driven in master reset");

    packet_bus_a: assert property (
        straps_q.packet_mode && qcfg_q == 4'hf && $stable(qcfg_q) |=>
        empty_side_out.status_bus_n == $past(packet_ready_n_q))
        else $error("packet status not on bus");

endmodule

// >>> bench/token_ring_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Other devices of an expansion ring
// ------------------------------------------------------------
module token_ring_model #(
    parameter int DEVS = 3
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic token_out,
    output logic      token_in
);
    logic [DEVS-2:0] ring_q;

    // Each other device holds the token one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ring_q <= '0;
        end
        else
        begin
            ring_q <= {ring_q[DEVS-3:0], token_out};
        end
    end

    // Last device loops back to the first
    assign token_in = ring_q[DEVS-2];
endmodule

// >>> bench/multi_queue_flag_bus_expansion_test.sv
`timescale 1ns/1ps

module multi_queue_flag_bus_expansion_test;
    typedef struct packed {
        logic       fs;
        logic       es;
        logic [4:0] addr;
        logic       foe;
        logic       eoe;
    } row_t;

    logic                    pclk;
    logic                    presetn;
    logic [11:0]             paddr;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [31:0]             pwdata;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic                    mrs_n;
    logic                    mode_sel;
    logic                    master_sel;
    logic                    packet_sel;
    logic [2:0]              ident;
    logic                    wr_en;
    logic [1:0]              wr_queue;
    logic                    w_eop;
    logic                    w_sop;
    logic                    rd_en;
    logic [1:0]              rd_queue;
    logic                    rd_sop;
    logic                    rd_switch;
    logic [3:0]              af_lvl;
    logic [3:0]              ae_lvl;
    logic [3:0]              not_empty;
    logic                    fs;
    logic                    es;
    logic [4:0]              addr;
    logic                    ftin;
    logic                    etin;
    logic                    full_flag_n;
    logic                    empty_flag_n;
    logic                    ready_flag_n;
    logic                    valid_flag_n;
    flag_bus_pkg::side_req_t freq;
    flag_bus_pkg::side_req_t ereq;
    flag_bus_pkg::side_out_t fout;
    flag_bus_pkg::side_out_t eout;
    logic [31:0]             rd;
    logic                    err;
    int                      num_errors;
    int                      checks;
    int                      nf;
    int                      ne;
    row_t                    rows [6];

    assign freq = {fs, addr, ftin};
    assign ereq = {es, addr, etin};

    always #5 pclk = ~pclk;

    multi_queue_flag_bus_expansion i_multi_queue_flag_bus_expansion (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .master_reset_n(mrs_n), .flag_bus_mode_select(mode_sel),
        .chain_master_select(master_sel), .packet_mode_select(packet_sel),
        .device_identity_inputs(ident), .wr_en(wr_en), .wr_queue(wr_queue),
        .write_end_of_packet_marker(w_eop),
        .write_start_of_packet_marker(w_sop), .rd_en(rd_en),
        .rd_queue(rd_queue), .read_start_of_packet_marker(rd_sop),
        .rd_queue_switch(rd_switch), .almost_full_level_n(af_lvl),
        .almost_empty_level_n(ae_lvl), .queue_not_empty(not_empty),
        .full_side_req(freq), .empty_side_req(ereq),
        .full_side_out(fout), .empty_side_out(eout),
        .almost_full_flag_n(full_flag_n), .almost_empty_flag_n(empty_flag_n),
        .packet_ready_flag_n(ready_flag_n), .output_valid_flag_n(valid_flag_n)
    );

    token_ring_model #(.DEVS(3)) i_token_ring_model_full (
        .pclk(pclk), .presetn(presetn), .token_out(fout.token_out),
        .token_in(ftin)
    );

    token_ring_model #(.DEVS(5)) i_token_ring_model_empty (
        .pclk(pclk), .presetn(presetn), .token_out(eout.token_out),
        .token_in(etin)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task wrap_up;
        begin
            $display("checks %0d errors %0d", checks, num_errors);
            if (num_errors == 0 && checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks++;
            if (seen !== exp)
            begin
                num_errors++;
                $display("Error %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task at(input int n);
        begin
            repeat (n) @(posedge pclk);
            #1;
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            paddr <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do
            begin
                @(posedge pclk);
                n++;
            end
            while (pready !== 1'b1 && n < 50);
            if (n >= 50)
            begin
                num_errors++;
                wrap_up();
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task wr(input logic [1:0] q, input logic s, input logic e);
        begin
            @(posedge pclk);
            wr_en <= 1'b1;
            wr_queue <= q;
            w_sop <= s;
            w_eop <= e;
            @(posedge pclk);
            wr_en <= 1'b0;
            w_sop <= 1'b0;
            w_eop <= 1'b0;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        {presetn, psel, penable, pwrite, mrs_n, mode_sel, master_sel} = '0;
        {wr_en, w_eop, w_sop, rd_en, rd_sop, rd_switch, fs, es} = '0;
        {paddr, pwdata, addr, wr_queue, rd_queue} = '0;
        {num_errors, checks} = '0;
        packet_sel = 1'b1;
        ident = 3'h2;
        af_lvl = 4'h3;
        ae_lvl = 4'h6;
        not_empty = 4'h5;
        rows = '{'{1'b1, 1'b0, 5'h0b, 1'b1, 1'b0},
                 '{1'b0, 1'b1, 5'h08, 1'b1, 1'b1},
                 '{1'b1, 1'b1, 5'h06, 1'b0, 1'b0},
                 '{1'b1, 1'b1, 5'h09, 1'b1, 1'b1},
                 '{1'b1, 1'b0, 5'h1a, 1'b0, 1'b1},
                 '{1'b1, 1'b1, 5'h08, 1'b1, 1'b1}};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        mrs_n <= 1'b1;
        at(3);
        chk("full_oe", fout.status_bus_oe, 1'b0);
        chk("empty_oe", eout.status_bus_oe, 1'b0);
        apb(1'b0, 12'h000, 32'h0);
        chk("qcfg", rd, 32'hf);
        apb(1'b1, 12'h00c, 32'h0);
        chk("unmapped_err", err, 1'b1);
        apb(1'b0, 12'h00c, 32'h0);
        chk("unmapped_data", rd, 32'h0);
        for (int q = 3; q >= 0; q--)
        begin
            @(posedge pclk);
            rd_queue <= q[1:0];
            wr_queue <= q[1:0];
            at(2);
            chk("ae_flag", empty_flag_n, ae_lvl[q]);
            chk("ov_flag", valid_flag_n, !not_empty[q]);
            chk("af_flag", full_flag_n, af_lvl[q]);
        end
        foreach (rows[i])
        begin
            @(posedge pclk);
            fs <= rows[i].fs;
            es <= rows[i].es;
            addr <= rows[i].addr;
            at(1);
            chk("full_oe", fout.status_bus_oe, rows[i].foe);
            chk("empty_oe", eout.status_bus_oe, rows[i].eoe);
            if (rows[i].foe)
                chk("full_bus", fout.status_bus_n, af_lvl);
            if (rows[i].eoe)
                chk("empty_bus", eout.status_bus_n, 4'hf);
        end
        @(posedge pclk);
        fs <= 1'b0;
        es <= 1'b0;
        apb(1'b1, 12'h000, 32'h5);
        at(3);
        chk("masked_bus", fout.status_bus_n, 4'hb);
        apb(1'b0, 12'h000, 32'h0);
        chk("qcfg_back", rd, 32'h5);
        wr(2'd0, 1'b0, 1'b1);
        at(4);
        chk("eop_alone", eout.status_bus_n[0], 1'b1);
        wr(2'd0, 1'b1, 1'b0);
        wr(2'd0, 1'b0, 1'b1);
        at(2);
        chk("fall_early", eout.status_bus_n[0], 1'b1);
        at(1);
        chk("fall_bus", eout.status_bus_n[0], 1'b0);
        chk("fall_flag", ready_flag_n, 1'b0);
        wr(2'd2, 1'b1, 1'b1);
        @(posedge pclk);
        rd_switch <= 1'b1;
        @(posedge pclk);
        rd_switch <= 1'b0;
        #1;
        chk("switch_early", eout.status_bus_n[2], 1'b1);
        at(1);
        chk("switch_lag", eout.status_bus_n[2], 1'b1);
        at(1);
        chk("switch_fall", eout.status_bus_n[2], 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk("count", rd, 32'h00010001);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", rd[5:0], 6'h3a);
        @(posedge pclk);
        rd_en <= 1'b1;
        rd_sop <= 1'b1;
        @(posedge pclk);
        rd_en <= 1'b0;
        rd_sop <= 1'b0;
        at(3);
        chk("rise_early", eout.status_bus_n[0], 1'b0);
        at(1);
        chk("rise_bus", eout.status_bus_n[0], 1'b1);
        chk("rise_flag", ready_flag_n, 1'b1);
        @(posedge pclk);
        mrs_n <= 1'b0;
        mode_sel <= 1'b1;
        master_sel <= 1'b1;
        at(2);
        @(posedge pclk);
        mrs_n <= 1'b1;
        at(1);
        chk("full_first", fout[2:0], 3'b111);
        chk("empty_first", eout[2:0], 3'b111);
        at(1);
        chk("full_after", fout[2:0], 3'b000);
        chk("empty_after", eout[2:0], 3'b000);
        nf = 0;
        ne = 0;
        for (int n = 2; n <= 8; n++)
        begin
            at(1);
            if (nf == 0 && fout.token_out === 1'b1)
                nf = n;
            if (ne == 0 && eout.token_out === 1'b1)
                ne = n;
        end
        chk("full_ring", nf, 3);
        chk("empty_ring", ne, 5);
        wrap_up();
    end
endmodule
